// >>> pkg/rtgc_consts.svh
// Register offsets, field positions, reset values and timing counts of the timer gate and capture block.
//
// Functional notes
// (RL1) Gating only when gate-enable bit set.
// (RL2) Gated: count only when gate equals polarity.
// (RL3) Two-bit select: pin, match, comparator one/two.
// (RL4) Comparator source raw or resynchronised, selectable.
// (RL5) Partner match source is a fixed timer.
// (RL6) Partner counts to period, then reloads zero.
// (RL7) Partner reload sends one gate pulse.
// (RL8) Shared instruction clock gives one increment per reload.
// (RL9) Capture picks one of three timers.
// (RL10) Capture copies whole 16-bit count coherently.
// (RL11) Mode field: falling, rising, 4th, 16th rising.
// (RL12) Every capture sets the capture flag.
// (RL13) Software clears the capture flag itself.
// (RL14) New capture overwrites an unread result.
// (RL15) Software sets capture pin as input.
// (RL16) Pin level sampled even when driven out.
// (RL17) Timer must be synchronous for capture.
// (RL18) Mask interrupt and clear flag around mode change.
// (RL19) Never clock timer from undivided oscillator.
// (RL20) Route bit picks pin; channel defaults differ.
// (RL21) Gate and capture pins synchronised first.
`ifndef RTGC_CONSTS_SVH
`define RTGC_CONSTS_SVH

`define RTGC_ADDR_W            5
`define RTGC_DATA_W            16

`define RTGC_OFS_GATE_CTRL     5'h00
`define RTGC_OFS_TIMER         5'h04
`define RTGC_OFS_PART_COUNT    5'h08
`define RTGC_OFS_PART_PERIOD   5'h0c
`define RTGC_OFS_CAP_CTRL      5'h10
`define RTGC_OFS_CAP_FLAG      5'h14
`define RTGC_OFS_CAP_RESULT    5'h18

`define RTGC_GC_RUN            0
`define RTGC_GC_GATE_EN        1
`define RTGC_GC_GATE_POL       2
`define RTGC_GC_SRC_LO         3
`define RTGC_GC_SRC_HI         4
`define RTGC_GC_CMP_SYNC       5
`define RTGC_GC_CLK_EXT        6
`define RTGC_GC_PART_RUN       7

`define RTGC_CC_MODE_LO        0
`define RTGC_CC_MODE_HI        3
`define RTGC_CC_TSEL_LO        4
`define RTGC_CC_TSEL_HI        5
`define RTGC_CC_ROUTE          6
`define RTGC_CF_FLAG           0

`define RTGC_MODE_FALL         4'h4
`define RTGC_MODE_RISE         4'h5
`define RTGC_MODE_RISE4        4'h6
`define RTGC_MODE_RISE16       4'h7
`define RTGC_PRESC_LAST4       4'h3
`define RTGC_PRESC_LAST16      4'hf

`define RTGC_TSEL_OWN          2'h0
`define RTGC_TSEL_B            2'h1
`define RTGC_TSEL_C            2'h2

`define RTGC_RST_PERIOD        8'hff
`define RTGC_ROUTE_RST_CH2     1'b1
`define RTGC_ROUTE_RST_CH3     1'b0
`define RTGC_INSN_DIV          4

`endif

// >>> pkg/rtgc_pkg.sv
// Types shared by the timer gate and capture modules.
package rtgc_pkg;

  // Gate source codes follow declaration order: 00 pin, 01 match, 10 and 11 comparators.
  typedef enum logic [1:0] {
    RTGC_SRC_PIN,
    RTGC_SRC_MATCH,
    RTGC_SRC_CMP1,
    RTGC_SRC_CMP2
  } rtgc_gate_src_t;

  // Whole state of the main block.
  typedef struct packed {
    logic [7:0]     divCnt;
    logic           run;
    logic           gateEn;
    logic           gatePol;
    rtgc_gate_src_t gateSrc;
    logic           cmpSync;
    logic           clkExt;
    logic           partnerRun;
    logic [15:0]    timer;
    logic           extPrev;
    logic           cmpOneHeld;
    logic           cmpTwoHeld;
    logic [3:0]     capMode;
    logic [1:0]     capTsel;
    logic           capRoute;
    logic           capFlag;
    logic [15:0]    capResult;
    logic [3:0]     presc;
    logic           pinPrev;
    logic [15:0]    rdata;
  } rtgc_main_state_t;

  // Whole state of the partner 8-bit timer.
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] period;
  } rtgc_partner_state_t;

endpackage

// >>> pkg/rtgc_partner_if.sv
// Interface between the main block and its partner 8-bit timer.
`timescale 1ns/10ps
interface rtgc_partner_if;
  logic       tick;
  logic       countWe;
  logic       periodWe;
  logic [7:0] wdata;
  logic [7:0] count;
  logic [7:0] period;
  logic       match;

  modport owner (output tick, output countWe, output periodWe, output wdata,
                 input count, input period, input match);
  modport unit  (input tick, input countWe, input periodWe, input wdata,
                 output count, output period, output match);
endinterface

// >>> logic/rtgc_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/10ps
module rtgc_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Raw and synchronised levels.
  input  wire logic [W-1:0] din,
  output      logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } rtgc_sync_state_t;

  rtgc_sync_state_t syncState_r;
  rtgc_sync_state_t syncState_nxt;

  // The first stage feeds only the second, so a metastable sample never reaches logic.
  always_comb begin
    syncState_nxt        = syncState_r;
    syncState_nxt.first  = din;
    syncState_nxt.second = syncState_r.first;
  end

  // State register.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncState_r <= '0;
    end else begin
      syncState_r <= syncState_nxt;
    end
  end

  assign dout = syncState_r.second;

endmodule

// >>> logic/rtgc_partner.sv
// Partner 8-bit timer that reloads at its period and pulses the gate logic.
`timescale 1ns/10ps
`include "rtgc_consts.svh"
module rtgc_partner (
  // Clock and reset.
  input  wire logic     core_clk,
  input  wire logic     rst_n,
  // Link to the main block.
  rtgc_partner_if.unit  pif
);

  rtgc_pkg::rtgc_partner_state_t partState_r;
  rtgc_pkg::rtgc_partner_state_t partState_nxt;

  // The pulse is the reload cycle itself, so a timer on the same tick sees it exactly once.
  assign pif.match  = pif.tick && (partState_r.count == partState_r.period); // [RL7]
  assign pif.count  = partState_r.count;
  assign pif.period = partState_r.period;

  // Count to the period, reload on the following tick; software writes take priority.
  always_comb begin
    partState_nxt = partState_r;
    if (pif.tick) begin
      if (partState_r.count == partState_r.period) begin
        partState_nxt.count = 8'h00; // [RL6]
      end else begin
        partState_nxt.count = partState_r.count + 8'h01; // [RL6]
      end
    end
    if (pif.countWe) begin
      partState_nxt.count = pif.wdata;
    end
    if (pif.periodWe) begin
      partState_nxt.period = pif.wdata;
    end
  end

  // State register.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      partState_r <= '{count: 8'h00, period: `RTGC_RST_PERIOD};
    end else begin
      partState_r <= partState_nxt;
    end
  end

endmodule

// >>> logic/rtgc_gate_capture.sv
// Gated 16-bit timer with partner match source and an input-capture channel.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "rtgc_consts.svh"
module rtgc_gate_capture #(
  parameter int CHANNEL  = 2,
  parameter int INSN_DIV = `RTGC_INSN_DIV
) (
  // Clock and reset.
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  // Register port.
  input  wire logic [`RTGC_ADDR_W-1:0]  regAddr,
  input  wire logic [`RTGC_DATA_W-1:0]  regWdata,
  input  wire logic                     regWrite,
  input  wire logic                     regRead,
  output      logic [`RTGC_DATA_W-1:0]  regRdata,
  // Pins.
  input  wire logic                     gateInputPin,
  input  wire logic                     timerCountClock,
  input  wire logic                     capturePin,
  input  wire logic                     capturePinAlt,
  // Internal sources.
  input  wire logic                     comparatorOne,
  input  wire logic                     comparatorTwo,
  input  wire logic [15:0]              timerCountB,
  input  wire logic [15:0]              timerCountC,
  // Status.
  output      logic [15:0]              timerCount,
  output      logic                     captureIrqFlag,
  output      logic                     partnerMatch
);

  localparam logic ROUTE_RST = (CHANNEL == 3) ? `RTGC_ROUTE_RST_CH3 : `RTGC_ROUTE_RST_CH2;
  localparam logic [7:0] DIV_LAST = 8'(INSN_DIV - 1);

  localparam rtgc_pkg::rtgc_main_state_t ST_RST = '{
    divCnt:     8'h00,
    run:        1'b0,
    gateEn:     1'b0,
    gatePol:    1'b0,
    gateSrc:    rtgc_pkg::RTGC_SRC_PIN,
    cmpSync:    1'b0,
    clkExt:     1'b0,
    partnerRun: 1'b0,
    timer:      16'h0000,
    extPrev:    1'b0,
    cmpOneHeld: 1'b0,
    cmpTwoHeld: 1'b0,
    capMode:    4'h0,
    capTsel:    `RTGC_TSEL_OWN,
    capRoute:   ROUTE_RST,
    capFlag:    1'b0,
    capResult:  16'h0000,
    presc:      4'h0,
    pinPrev:    1'b0,
    rdata:      16'h0000
  };

  rtgc_pkg::rtgc_main_state_t st_r;
  rtgc_pkg::rtgc_main_state_t st_nxt;

  logic [3:0] pinSync;
  logic       gateSync;
  logic       extSync;
  logic       capSync;
  logic       capAltSync;

  logic       insnTick;
  logic       countTick;
  logic       gateLevel;
  logic       gateOpen;
  logic       capPinLevel;
  logic       capRise;
  logic       capFall;
  logic       capTake;
  logic [15:0] capSource;
  logic       wrGate;
  logic       wrTimer;
  logic       wrCapCtrl;
  logic       wrCapFlag;

  rtgc_partner_if pif ();

  // Pins pass a two-flop stage before any gate or edge logic looks at them.
  rtgc_sync #(.W(4)) u_pinSync ( // [RL21]
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .din      ({capturePinAlt, capturePin, timerCountClock, gateInputPin}),
    .dout     (pinSync)
  );

  assign gateSync   = pinSync[0];
  assign extSync    = pinSync[1];
  assign capSync    = pinSync[2];
  assign capAltSync = pinSync[3];

  // The partner is wired to this unit only, so each timer has its own fixed match source.
  rtgc_partner u_partner ( // [RL5]
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pif      (pif)
  );

  // Write decode for the register port.
  assign wrGate    = regWrite && (regAddr == `RTGC_OFS_GATE_CTRL);
  assign wrTimer   = regWrite && (regAddr == `RTGC_OFS_TIMER);
  assign wrCapCtrl = regWrite && (regAddr == `RTGC_OFS_CAP_CTRL);
  assign wrCapFlag = regWrite && (regAddr == `RTGC_OFS_CAP_FLAG);

  // Instruction clock is a one-cycle enable from the divider; the partner shares it.
  assign insnTick     = (st_r.divCnt == DIV_LAST);
  assign pif.tick     = insnTick && st_r.partnerRun;
  assign pif.countWe  = regWrite && (regAddr == `RTGC_OFS_PART_COUNT);
  assign pif.periodWe = regWrite && (regAddr == `RTGC_OFS_PART_PERIOD);
  assign pif.wdata    = regWdata[7:0];

  // The external source counts on rising edges of the synchronised pin, the internal one on the tick.
  assign countTick = st_r.clkExt ? (extSync && !st_r.extPrev) : insnTick;

  // Gate source multiplexer.
  always_comb begin
    unique case (st_r.gateSrc) // [RL3]
      rtgc_pkg::RTGC_SRC_PIN:   gateLevel = gateSync;
      rtgc_pkg::RTGC_SRC_MATCH: gateLevel = pif.match; // [RL8]
      rtgc_pkg::RTGC_SRC_CMP1:  gateLevel = st_r.cmpSync ? st_r.cmpOneHeld : comparatorOne; // [RL4]
      rtgc_pkg::RTGC_SRC_CMP2:  gateLevel = st_r.cmpSync ? st_r.cmpTwoHeld : comparatorTwo; // [RL4]
    endcase
  end

  // With gating off the timer runs freely; with it on only a matching level lets it count.
  assign gateOpen = !st_r.gateEn || (gateLevel == st_r.gatePol); // [RL1] [RL2]

  // Capture pin choice and edge detection; the pad level is used whatever its direction.
  assign capPinLevel = st_r.capRoute ? capAltSync : capSync; // [RL20] [RL16]
  assign capRise     = capPinLevel && !st_r.pinPrev;
  assign capFall     = !capPinLevel && st_r.pinPrev;

  // Event qualification by mode; prescaled modes capture on the last rising edge of a group.
  always_comb begin
    unique case (st_r.capMode) // [RL11]
      `RTGC_MODE_FALL:   capTake = capFall;
      `RTGC_MODE_RISE:   capTake = capRise;
      `RTGC_MODE_RISE4:  capTake = capRise && (st_r.presc == `RTGC_PRESC_LAST4);
      `RTGC_MODE_RISE16: capTake = capRise && (st_r.presc == `RTGC_PRESC_LAST16);
      default:           capTake = 1'b0;
    endcase
  end

  // Timer chosen for capture.
  always_comb begin
    unique case (st_r.capTsel) // [RL9]
      `RTGC_TSEL_B: capSource = timerCountB;
      `RTGC_TSEL_C: capSource = timerCountC;
      default:      capSource = st_r.timer;
    endcase
  end

  // Next-state logic for the whole block.
  always_comb begin
    st_nxt = st_r;

    // Instruction clock divider.
    st_nxt.divCnt  = insnTick ? 8'h00 : (st_r.divCnt + 8'h01);
    st_nxt.extPrev = extSync;
    st_nxt.pinPrev = capPinLevel;

    // Resynchronised comparator levels only move on the timer's own count edge.
    if (countTick) begin
      st_nxt.cmpOneHeld = comparatorOne; // [RL4]
      st_nxt.cmpTwoHeld = comparatorTwo; // [RL4]
    end

    // Counting; a software write in the same cycle wins over the increment.
    if (st_r.run && countTick && gateOpen) begin
      st_nxt.timer = st_r.timer + 16'h0001; // [RL2] [RL8]
    end
    if (wrTimer) begin
      st_nxt.timer = regWdata;
    end

    // Gate control register.
    if (wrGate) begin
      st_nxt.run        = regWdata[`RTGC_GC_RUN];
      st_nxt.gateEn     = regWdata[`RTGC_GC_GATE_EN]; // [RL1]
      st_nxt.gatePol    = regWdata[`RTGC_GC_GATE_POL];
      st_nxt.gateSrc    = rtgc_pkg::rtgc_gate_src_t'(regWdata[`RTGC_GC_SRC_HI:`RTGC_GC_SRC_LO]); // [RL3]
      st_nxt.cmpSync    = regWdata[`RTGC_GC_CMP_SYNC]; // [RL4]
      st_nxt.clkExt     = regWdata[`RTGC_GC_CLK_EXT];
      st_nxt.partnerRun = regWdata[`RTGC_GC_PART_RUN];
    end

    // Prescaler counts rising edges in the grouped modes.
    if (capRise && ((st_r.capMode == `RTGC_MODE_RISE4) || (st_r.capMode == `RTGC_MODE_RISE16))) begin
      st_nxt.presc = capTake ? 4'h0 : (st_r.presc + 4'h1); // [RL11]
    end

    // Any result still unread is simply replaced; there is no overrun indication.
    if (capTake) begin
      st_nxt.capResult = capSource; // [RL10] [RL14]
    end

    // A mode change restarts the prescaler so a group never straddles two modes.
    if (wrCapCtrl) begin
      st_nxt.capMode  = regWdata[`RTGC_CC_MODE_HI:`RTGC_CC_MODE_LO]; // [RL11]
      st_nxt.capTsel  = regWdata[`RTGC_CC_TSEL_HI:`RTGC_CC_TSEL_LO]; // [RL9]
      st_nxt.capRoute = regWdata[`RTGC_CC_ROUTE]; // [RL20]
      st_nxt.presc    = 4'h0;
    end

    // Flag: software clears by writing one, and a capture in the same cycle wins.
    if (wrCapFlag && regWdata[`RTGC_CF_FLAG]) begin
      st_nxt.capFlag = 1'b0; // [RL13]
    end
    if (capTake) begin
      st_nxt.capFlag = 1'b1; // [RL12]
    end

    // Read data stand for exactly the cycle after the strobe.
    st_nxt.rdata = 16'h0000;
    if (regRead) begin
      unique case (regAddr)
        `RTGC_OFS_GATE_CTRL:   st_nxt.rdata = {8'h00, st_r.partnerRun, st_r.clkExt, st_r.cmpSync,
                                               st_r.gateSrc, st_r.gatePol, st_r.gateEn, st_r.run};
        `RTGC_OFS_TIMER:       st_nxt.rdata = st_r.timer;
        `RTGC_OFS_PART_COUNT:  st_nxt.rdata = {8'h00, pif.count};
        `RTGC_OFS_PART_PERIOD: st_nxt.rdata = {8'h00, pif.period};
        `RTGC_OFS_CAP_CTRL:    st_nxt.rdata = {9'h000, st_r.capRoute, st_r.capTsel, st_r.capMode};
        `RTGC_OFS_CAP_FLAG:    st_nxt.rdata = {15'h0000, st_r.capFlag};
        `RTGC_OFS_CAP_RESULT:  st_nxt.rdata = st_r.capResult; // [RL10]
        default:               st_nxt.rdata = 16'h0000;
      endcase
    end
  end

  // State register.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs; the match pulse is combinational so it lines up with the shared tick.
  assign regRdata       = st_r.rdata;
  assign timerCount     = st_r.timer;
  assign captureIrqFlag = st_r.capFlag;
  assign partnerMatch   = pif.match;

endmodule

// >>> test/rtgc_gate_capture_monitor.sv
// Port-level assertions for the timer gate and capture block.
`timescale 1ns/10ps
module rtgc_gate_capture_monitor #(
  parameter int CHANNEL  = 2,
  parameter int INSN_DIV = 4
) (
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Register port.
  input wire logic [4:0]  regAddr,
  input wire logic [15:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [15:0] regRdata,
  // Pins and status.
  input wire logic        capturePin,
  input wire logic        capturePinAlt,
  input wire logic [15:0] timerCount,
  input wire logic        captureIrqFlag,
  input wire logic        partnerMatch
);
  // All checks share the core clock; reset silences them.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Read answers stand for one cycle only and carry the live value.
  a_rdata_idle: assert property (!regRead |=> regRdata == 16'h0000)
    else $error("read data not zero");
  a_timer_read: assert property (regRead && regAddr == 5'h04 |=> regRdata == $past(timerCount))
    else $error("timer read wrong");
  a_flag_read: assert property (
    regRead && regAddr == 5'h14 |=> regRdata == {15'h0000, $past(captureIrqFlag)})
    else $error("flag read wrong");
  // A timer write wins; otherwise the count holds or steps by one.
  a_timer_load: assert property (regWrite && regAddr == 5'h04 |=> timerCount == $past(regWdata))
    else $error("timer write lost");
  a_timer_step: assert property (
    !(regWrite && regAddr == 5'h04) |=>
    timerCount == $past(timerCount) || timerCount == $past(timerCount) + 16'h0001)
    else $error("timer jumped");
  // The flag only falls by a software clear.
  a_flag_sticky: assert property (
    captureIrqFlag && !(regWrite && regAddr == 5'h14 && regWdata[0]) |=> captureIrqFlag)
    else $error("flag cleared by itself");
  // A capture follows a pad change by the synchroniser delay.
  a_flag_cause: assert property (
    $rose(captureIrqFlag) |-> $past(capturePin, 3) != $past(capturePin, 4)
    || $past(capturePinAlt, 3) != $past(capturePinAlt, 4))
    else $error("flag without pin edge");
  // The reload pulse is one cycle and ticks are several cycles apart.
  a_match_pulse: assert property (partnerMatch |=> (!partnerMatch) [*3])
    else $error("match pulse too long");
endmodule

bind rtgc_gate_capture rtgc_gate_capture_monitor #(.CHANNEL(CHANNEL), .INSN_DIV(INSN_DIV)) mon_u (
  .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .capturePin(capturePin),
  .capturePinAlt(capturePinAlt), .timerCount(timerCount), .captureIrqFlag(captureIrqFlag),
  .partnerMatch(partnerMatch));

// >>> test/rtgc_pin_model.sv
// Far-side pins of the block: gate, capture, comparator and count clock sources.
`timescale 1ns/10ps
module rtgc_pin_model (
  // Clock.
  input wire logic core_clk,
  // Pin levels.
  output logic     gatePin,
  output logic     capPin,
  output logic     capAlt,
  output logic     cmpOne,
  output logic     cmpTwo,
  output logic     extClk
);
  // All pins start low so nothing toggles during reset.
  initial begin
    {gatePin, capPin, capAlt, cmpOne, cmpTwo, extClk} = 6'h00;
  end
  // The external count clock runs free, slower than the instruction tick.
  always begin
    repeat (5) @(posedge core_clk);
    extClk <= ~extClk;
  end
  // Gate and comparator levels change just after an edge.
  task automatic setLevels(input logic [2:0] lv);
    @(posedge core_clk);
    {gatePin, cmpOne, cmpTwo} <= lv;
  endtask
  // Capture pins are driven as inputs; each level outlasts the synchroniser.
  task automatic setCap(input logic alt, input logic lv);
    @(posedge core_clk);
    if (alt) capAlt <= lv;
    else capPin <= lv;
    repeat (5) @(posedge core_clk);
    #1;
  endtask
endmodule

// >>> test/rtgc_gate_capture_tb.sv
// Self-checking testbench of the timer gate and capture block.
`timescale 1ns/10ps
`include "rtgc_consts.svh"
module rtgc_gate_capture_tb;
  // Design ports.
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  regAddr = 5'h00;
  logic [15:0] regWdata = 16'h0000;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [15:0] regRdata;
  logic        gatePin, capPin, capAlt, cmpOne, cmpTwo, extClk;
  logic [15:0] timerCountB = 16'h5a5a;
  logic [15:0] timerCountC = 16'hc3c3;
  logic [15:0] timerCount;
  logic        captureIrqFlag;
  logic        partnerMatch;
  // Bookkeeping and stimulus tables; gTab is {control, gate/cmp1/cmp2 levels, counts}.
  int          errCount = 0;
  int          nChecks = 0;
  int          t;
  logic [15:0] v;
  logic [11:0] gTab [10] = '{12'h011, 12'h031, 12'h038, 12'h070, 12'h079,
                             12'h175, 12'h172, 12'h3f3, 12'h1f4, 12'h411};
  logic [3:0]  mTab [4] = '{`RTGC_MODE_FALL, `RTGC_MODE_RISE, `RTGC_MODE_RISE4, `RTGC_MODE_RISE16};
  int          nTab [4] = '{1, 1, 4, 16};
  logic [15:0] sTab [3] = '{16'h1234, 16'h5a5a, 16'hc3c3};

  rtgc_gate_capture #(.CHANNEL(2), .INSN_DIV(4)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .gateInputPin(gatePin),
    .timerCountClock(extClk), .capturePin(capPin), .capturePinAlt(capAlt),
    .comparatorOne(cmpOne), .comparatorTwo(cmpTwo), .timerCountB(timerCountB),
    .timerCountC(timerCountC), .timerCount(timerCount), .captureIrqFlag(captureIrqFlag),
    .partnerMatch(partnerMatch));
  rtgc_pin_model pm_u (.core_clk(core_clk), .gatePin(gatePin), .capPin(capPin), .capAlt(capAlt),
    .cmpOne(cmpOne), .cmpTwo(cmpTwo), .extClk(extClk));

  // Core clock at 50 MHz.
  always #10 core_clk = ~core_clk;

  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bus cycles: one strobe cycle, read data taken in the cycle after.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    // Let the edge that takes the write settle, so a caller's check sees its effect.
    #1;
  endtask
  task automatic rdChk(input string nm, input logic [4:0] a, input logic [15:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    check(nm, regRdata, e);
  endtask
  task automatic cap(input logic alt);
    pm_u.setCap(alt, 1'b1);
    pm_u.setCap(alt, 1'b0);
  endtask
  // Waits for the next reload pulse; t counts the cycles skipped.
  task automatic waitMatch(output int n);
    n = 0;
    @(posedge core_clk);
    #1;
    while (partnerMatch !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask
  task automatic testDone;
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge core_clk);
    errCount++;
    testDone;
  end

  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rdChk("gate ctrl", `RTGC_OFS_GATE_CTRL, 16'h0000);
    rdChk("period", `RTGC_OFS_PART_PERIOD, 16'h00ff);
    rdChk("cap ctrl", `RTGC_OFS_CAP_CTRL, 16'h0040);
    rdChk("result", `RTGC_OFS_CAP_RESULT, 16'h0000);
    rdChk("unmapped", 5'h1c, 16'h0000);
    // Gate enable, polarity, source and resync cases; a held timer stays at zero.
    foreach (gTab[i]) begin
      wr(`RTGC_OFS_GATE_CTRL, 16'h0000);
      wr(`RTGC_OFS_TIMER, 16'h0000);
      pm_u.setLevels(gTab[i][3:1]);
      repeat (3) @(posedge core_clk);
      wr(`RTGC_OFS_GATE_CTRL, {8'h00, gTab[i][11:4]});
      repeat (48) @(posedge core_clk);
      wr(`RTGC_OFS_GATE_CTRL, 16'h0000);
      @(posedge core_clk);
      #1;
      check("gated count", 16'(timerCount != 16'h0000), 16'(gTab[i][0]));
    end
    // Partner reload at period 2 gates the timer once per reload.
    wr(`RTGC_OFS_PART_PERIOD, 16'h0002);
    wr(`RTGC_OFS_PART_COUNT, 16'h0000);
    wr(`RTGC_OFS_GATE_CTRL, 16'h008f);
    waitMatch(t);
    waitMatch(t);
    check("match gap", 16'(t + 1), 16'h000c);
    v = timerCount;
    repeat (5) waitMatch(t);
    check("timer per reload", timerCount - v, 16'h0005);
    wr(`RTGC_OFS_GATE_CTRL, 16'h0000);
    rdChk("part count", `RTGC_OFS_PART_COUNT, 16'h0000);
    rdChk("part period", `RTGC_OFS_PART_PERIOD, 16'h0002);
    // Every mode captures on exactly its own edge count.
    foreach (mTab[i]) begin
      wr(`RTGC_OFS_CAP_CTRL, {12'h000, mTab[i]});
      wr(`RTGC_OFS_CAP_FLAG, 16'h0001);
      for (int k = 1; k <= nTab[i]; k++) begin
        pm_u.setCap(1'b0, 1'b1);
        check("flag rise", 16'(captureIrqFlag), 16'(k == nTab[i] && i > 0));
        pm_u.setCap(1'b0, 1'b0);
        check("flag fall", 16'(captureIrqFlag), 16'(k == nTab[i]));
      end
      wr(`RTGC_OFS_CAP_FLAG, 16'h0001);
      check("flag clear", 16'(captureIrqFlag), 16'h0000);
    end
    // Route bit set: only the alternate pin captures.
    wr(`RTGC_OFS_CAP_CTRL, 16'h0045);
    cap(1'b0);
    check("primary ignored", 16'(captureIrqFlag), 16'h0000);
    cap(1'b1);
    check("alt captures", 16'(captureIrqFlag), 16'h0001);
    // Timer select picks own, second and third timer values.
    wr(`RTGC_OFS_TIMER, 16'h1234);
    for (int i = 0; i < 3; i++) begin
      wr(`RTGC_OFS_CAP_CTRL, 16'(i << 4) | 16'h0005);
      cap(1'b0);
      rdChk("selected result", `RTGC_OFS_CAP_RESULT, sTab[i]);
    end
    // An unread result is overwritten and cannot be written.
    wr(`RTGC_OFS_CAP_CTRL, 16'h0005);
    wr(`RTGC_OFS_TIMER, 16'habcd);
    cap(1'b0);
    wr(`RTGC_OFS_TIMER, 16'h0777);
    cap(1'b0);
    rdChk("overwrite", `RTGC_OFS_CAP_RESULT, 16'h0777);
    wr(`RTGC_OFS_CAP_RESULT, 16'hffff);
    rdChk("result ro", `RTGC_OFS_CAP_RESULT, 16'h0777);
    testDone;
  end
endmodule
